// ### logic/efpc_pkg.sv
// shared constants for the external flash port host controller
package efpc_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  // strobe timing in ns, our own defaults
  localparam int T_SETUP_NS = 50;
  localparam int T_PULSE_NS = 75;
  localparam int T_HOLD_NS = 25;
  localparam int T_RESET_NS = 100;
  localparam int CLK_NS = 25;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC = (T_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_RESET
  } efpc_state_t;
endpackage

// ### logic/efpc_pin_drive.sv
// output enable gating of the shared flash pins
module efpc_pin_drive #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input wire logic own_bus,
  input wire logic drive_data,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe
);
  // every line released unless this master owns the bus
  assign addr_o = addr_in;
  assign addr_oe = own_bus;
  assign dq_o = data_in;
  assign dq_oe = own_bus & drive_data;
endmodule

// ### logic/efpc_host.sv
// host controller driving the shared external flash port
// Summary of operation
// - select is held low through each access, high otherwise for standby
// - host releases reset driver whenever idle, drives it during accesses and resets
// - read enable low only in the pulse phase of reads; flash then drives data
// - each write pulses the write strobe low
// - board should hold write-protect high
// - host drives data on writes, flash drives it on reads
module efpc_host #(
  parameter int ADDR_W = efpc_pkg::ADDR_W,
  parameter int DATA_W = efpc_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_reset,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic flash_done,
  output logic chip_sel_n,
  output logic chip_sel_n_oe,
  output logic read_en_n,
  output logic read_en_n_oe,
  output logic write_strobe_n,
  output logic write_strobe_n_oe,
  output logic flash_reset_n,
  output logic flash_reset_n_oe,
  output logic byte_wide_n,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic operation_done_flag
);
  typedef struct packed {
    efpc_pkg::efpc_state_t st;
    logic [efpc_pkg::CNT_W-1:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rsp;
    logic done;
  } efpc_regs_t;

  efpc_regs_t cur_ff;
  efpc_regs_t nxt_cur;

  localparam logic [efpc_pkg::CNT_W-1:0] SETUP_N = efpc_pkg::CNT_W'(efpc_pkg::SETUP_CYC);
  localparam logic [efpc_pkg::CNT_W-1:0] PULSE_N = efpc_pkg::CNT_W'(efpc_pkg::PULSE_CYC);
  localparam logic [efpc_pkg::CNT_W-1:0] HOLD_N = efpc_pkg::CNT_W'(efpc_pkg::HOLD_CYC);
  localparam logic [efpc_pkg::CNT_W-1:0] RESET_N = efpc_pkg::CNT_W'(efpc_pkg::RESET_CYC);

  wire logic busy = cur_ff.st != efpc_pkg::ST_IDLE;
  // counters load n and run down to one, so each phase lasts n cycles
  wire logic last = cur_ff.cnt == efpc_pkg::CNT_ONE;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp = 1'b0;
    // open-drain done line, low means still busy
    nxt_cur.done = operation_done_flag;
    if (cur_ff.cnt != efpc_pkg::CNT_ZERO) begin
      nxt_cur.cnt = cur_ff.cnt - efpc_pkg::CNT_ONE;
    end
    case (cur_ff.st)
      efpc_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_cur.addr = req_addr;
          nxt_cur.wdata = req_wdata;
          nxt_cur.wr = req_write;
          if (req_reset) begin
            nxt_cur.st = efpc_pkg::ST_RESET;
            nxt_cur.cnt = RESET_N;
          end else begin
            nxt_cur.st = efpc_pkg::ST_SETUP;
            nxt_cur.cnt = SETUP_N;
          end
        end
      end
      efpc_pkg::ST_SETUP: begin
        if (last) begin
          nxt_cur.st = efpc_pkg::ST_PULSE;
          nxt_cur.cnt = PULSE_N;
        end
      end
      efpc_pkg::ST_PULSE: begin
        if (last) begin
          // read data sampled while read enable still low
          if (!cur_ff.wr) begin
            nxt_cur.rdata = dq_i;
          end
          nxt_cur.st = efpc_pkg::ST_HOLD;
          nxt_cur.cnt = HOLD_N;
        end
      end
      efpc_pkg::ST_HOLD: begin
        // address and data held past strobe rise for capture
        if (last) begin
          nxt_cur.st = efpc_pkg::ST_IDLE;
          nxt_cur.rsp = 1'b1;
        end
      end
      efpc_pkg::ST_RESET: begin
        if (last) begin
          nxt_cur.st = efpc_pkg::ST_IDLE;
          nxt_cur.rsp = 1'b1;
        end
      end
      default: nxt_cur.st = efpc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  wire logic in_access = busy && cur_ff.st != efpc_pkg::ST_RESET;
  wire logic in_pulse = cur_ff.st == efpc_pkg::ST_PULSE;

  assign req_ready = !busy;
  assign rsp_valid = cur_ff.rsp;
  assign rsp_rdata = cur_ff.rdata;
  assign flash_done = cur_ff.done;
  assign chip_sel_n = !in_access;
  assign chip_sel_n_oe = busy;
  assign read_en_n = !(in_pulse && !cur_ff.wr);
  assign read_en_n_oe = busy;
  assign write_strobe_n = !(in_pulse && cur_ff.wr);
  assign write_strobe_n_oe = busy;
  // reset pin driven only while host owns the bus, released otherwise
  assign flash_reset_n = cur_ff.st != efpc_pkg::ST_RESET;
  assign flash_reset_n_oe = busy;
  // no write-protect output exists: the board fixes its level
  assign byte_wide_n = 1'b1;

  efpc_pin_drive #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_pins (
    .own_bus(busy),
    .drive_data(in_access && cur_ff.wr),
    .addr_in(cur_ff.addr),
    .data_in(cur_ff.wdata),
    .addr_o(addr_o),
    .addr_oe(addr_oe),
    .dq_o(dq_o),
    .dq_oe(dq_oe)
  );

  a_strobe_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(!read_en_n && !write_strobe_n))
    else $error("read and write strobes low together");
  a_select_on_strobe: assert property (@(posedge clk) disable iff (rst)
    (!read_en_n || !write_strobe_n) |-> !chip_sel_n)
    else $error("strobe without select");
  a_write_data_held: assert property (@(posedge clk) disable iff (rst)
    $rose(write_strobe_n) |-> dq_oe && addr_oe && $stable(dq_o))
    else $error("data dropped at strobe rise");
  a_no_write_in_reset: assert property (@(posedge clk) disable iff (rst)
    !flash_reset_n |-> write_strobe_n && chip_sel_n)
    else $error("write during flash reset");
  a_release_idle: assert property (@(posedge clk) disable iff (rst)
    req_ready |-> !flash_reset_n_oe && !addr_oe && !dq_oe)
    else $error("pins driven while idle");
  a_read_no_drive: assert property (@(posedge clk) disable iff (rst)
    !read_en_n |-> !dq_oe)
    else $error("host drives data during read");
  a_access_length: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_ready && !req_reset) |=> !rsp_valid [*6] ##1 rsp_valid)
    else $error("access length wrong");
  a_byte_high: assert property (@(posedge clk) disable iff (rst)
    byte_wide_n)
    else $error("byte width select low");
  a_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_ready && req_reset) |=> !flash_reset_n [*4] ##1 flash_reset_n)
    else $error("reset pulse length wrong");
  a_read_capture: assert property (@(posedge clk) disable iff (rst)
    (in_pulse && last && !cur_ff.wr) |=> rsp_rdata == $past(dq_i))
    else $error("read data not captured");
  a_addr_held: assert property (@(posedge clk) disable iff (rst)
    $rose(write_strobe_n) |-> addr_oe && $stable(addr_o) && !chip_sel_n)
    else $error("address moved at strobe rise");
  a_select_idle: assert property (@(posedge clk) disable iff (rst)
    req_ready |-> chip_sel_n && read_en_n && write_strobe_n && flash_reset_n)
    else $error("control pin active while idle");
  // first cycle after reset skipped: flag register was just cleared
  a_done_follows: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> flash_done == $past(operation_done_flag))
    else $error("done flag not followed");
  a_setup_select: assert property (@(posedge clk) disable iff (rst)
    $fell(chip_sel_n) |-> read_en_n && write_strobe_n)
    else $error("strobe without select setup");
  a_data_on_write: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |-> dq_oe)
    else $error("write strobe without data driven");
  a_reset_quiet: assert property (@(posedge clk) disable iff (rst)
    !flash_reset_n |-> !dq_oe && read_en_n)
    else $error("data or read active during flash reset");

  c_write: cover property (@(posedge clk) disable iff (rst) $rose(write_strobe_n));
  c_read: cover property (@(posedge clk) disable iff (rst) $rose(read_en_n));
  c_reset: cover property (@(posedge clk) disable iff (rst) $rose(flash_reset_n));
  c_done_wait: cover property (@(posedge clk) disable iff (rst) $rose(flash_done));
endmodule

// ### verif/efpc_flash_model.sv
// behavioural flash die on the shared port
module efpc_flash_model (
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic flash_reset_n,
  input wire logic byte_wide_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_drive,
  output logic operation_done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic busy = 1'b0;
  // word mode only, no byte lanes
  wire logic live = !sel_n && flash_reset_n && byte_wide_n;
  assign dq_drive = live && !rd_n;
  // released bus shows the inverse, never a stale word
  assign dq_out = dq_drive ? mem[addr[3:0]] : ~mem[addr[3:0]];
  assign operation_done_flag = !busy; // pulled up when released
  // write-protect tied high on the board
  // busy ends off the clock edge so the host never samples it in a race
  always @(posedge wr_n or negedge flash_reset_n) begin
    if (flash_reset_n === 1'b0) begin
      busy = 1'b0;
    end else if (live && wr_n === 1'b1) begin
      mem[addr[3:0]] = dq_in;
      busy = 1'b1;
      #140 busy = 1'b0;
    end
  end
endmodule

// ### verif/external_flash_port_control_tb.sv
// self-checking bench for the flash port host controller
module external_flash_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACC = efpc_pkg::SETUP_CYC + efpc_pkg::PULSE_CYC + efpc_pkg::HOLD_CYC;
  logic clk, rst, req_valid, req_write, req_reset, req_ready, rsp_valid, flash_done;
  logic [20:0] req_addr, addr_o;
  logic [15:0] req_wdata, rsp_rdata, dq_o, dq_f;
  logic cs, cs_oe, rd, rd_oe, wr, wr_oe, frst, frst_oe, bw, addr_oe, dq_oe, done_flag, f_drv;
  logic [15:0] pat [2] = '{16'hA5C3, 16'h3C5A};
  int err_total, check_count;
  wire logic [15:0] dq_w = dq_oe ? dq_o : dq_f;
  efpc_host dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_reset(req_reset), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_done(flash_done), .chip_sel_n(cs),
    .chip_sel_n_oe(cs_oe), .read_en_n(rd), .read_en_n_oe(rd_oe), .write_strobe_n(wr),
    .write_strobe_n_oe(wr_oe), .flash_reset_n(frst), .flash_reset_n_oe(frst_oe),
    .byte_wide_n(bw), .addr_o(addr_o), .addr_oe(addr_oe), .dq_o(dq_o), .dq_oe(dq_oe),
    .dq_i(dq_w), .operation_done_flag(done_flag));
  // released control lines sit at their pull-up
  efpc_flash_model flash (.sel_n(cs_oe ? cs : 1'b1), .rd_n(rd_oe ? rd : 1'b1),
    .wr_n(wr_oe ? wr : 1'b1), .flash_reset_n(frst_oe ? frst : 1'b1), .byte_wide_n(bw),
    .addr(addr_oe ? addr_o : ~addr_o), .dq_in(dq_w), .dq_out(dq_f), .dq_drive(f_drv),
    .operation_done_flag(done_flag));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; counts cycles to answer, active strobe cycles, select cycles
  task automatic access(input logic w, r, input logic [20:0] a, input logic [15:0] d,
                        output int n, output int lo, output int sl);
    @(negedge clk);
    {req_valid, req_write, req_reset, req_addr, req_wdata} = {1'b1, w, r, a, d};
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      err_total++;
      tally_and_finish();
    end
    @(negedge clk);
    req_valid = 1'b0;
    lo = 0;
    sl = 0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) begin
      lo += ((r ? frst : w ? wr : rd) === 1'b0);
      sl += (cs === 1'b0);
      if (f_drv && dq_oe) chk({f_drv, dq_oe}, 0);
      @(negedge clk);
    end
    if (n == 20) begin
      err_total++;
      tally_and_finish();
    end
    chk({cs_oe, rd_oe, wr_oe, frst_oe, addr_oe, dq_oe}, 0);
  endtask
  task automatic t_idle();
    chk({cs_oe, rd_oe, wr_oe, frst_oe, addr_oe, dq_oe, rsp_valid}, 0);
    chk({req_ready, bw, cs, wr, frst}, 5'h1F);
    $display("idle test done");
  endtask
  task automatic t_write_read();
    int n, lo, sl;
    for (int i = 0; i < 4; i++) begin
      access(i < 2, 1'b0, 21'h1AAAA0 + 21'(i % 2), pat[i % 2], n, lo, sl);
      chk(n, ACC);
      chk(lo, efpc_pkg::PULSE_CYC);
      chk(sl, ACC);
      if (i > 1) chk(rsp_rdata, pat[i % 2]);
    end
    $display("write read test done");
  endtask
  task automatic t_done_flag();
    int n, lo, sl;
    access(1'b1, 1'b0, 21'h000005, 16'h0F0F, n, lo, sl);
    chk(flash_done, 1'b0);
    for (n = 0; n < 20 && flash_done !== 1'b1; n++) @(negedge clk);
    chk(n < 20, 1'b1);
    if (n == 20) tally_and_finish();
    $display("done flag test done");
  endtask
  task automatic t_flash_reset();
    int n, lo, sl;
    access(1'b0, 1'b1, 21'h0, 16'h0, n, lo, sl);
    chk(n, efpc_pkg::RESET_CYC);
    chk(lo, efpc_pkg::RESET_CYC);
    chk(sl, 0);
    $display("flash reset test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {req_valid, req_write, req_reset, req_addr, req_wdata} = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_idle();
    t_write_read();
    t_done_flag();
    t_flash_reset();
    tally_and_finish();
  end
endmodule
